// file: dps_pkg.sv
package dps_pkg;
    // Power-system cycle based timing
    localparam logic [4:0]  MEM_DUR_MIN     = 5'h05;
    localparam logic [4:0]  MEM_DUR_MAX     = 5'h19;
    localparam logic [4:0]  MEM_DUR_RST     = 5'h0A;
    localparam logic [2:0]  VALID_CYCLES    = 3'h5;
    // Nominal magnitude scale and percent-of-nominal thresholds
    localparam logic [15:0] MAG_NOM_RST     = 16'h4000;
    localparam int          PCT_VALID       = 80;
    localparam int          PCT_RESTORE     = 10;
    // CVT time constants in 0.01 ms steps
    localparam logic [9:0]  CVT_TC_MIN      = 10'h019;
    localparam logic [9:0]  CVT_TC_MAX      = 10'h3E8;
    localparam logic [9:0]  CVT_TC_RST      = 10'h064;
    localparam logic [1:0]  SRC_LINE        = 2'h0;
    localparam logic [1:0]  SRC_BKR1        = 2'h1;
    localparam logic [1:0]  SRC_BKR2        = 2'h2;
    localparam int          NUM_ZONES       = 10;

    typedef struct packed {
        logic [15:0] re;
        logic [15:0] im;
    } dps_phasor_s;

    typedef struct packed {
        dps_phasor_s v1;
        dps_phasor_s i1;
        logic [15:0] mag;
    } dps_src_s;

    typedef struct packed {
        logic [9:0] first;
        logic [9:0] second;
        logic [9:0] third;
    } dps_cvt_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_VALID = 2'b01,
        ST_HOLD  = 2'b10,
        ST_CHECK = 2'b11
    } dps_mem_e;
endpackage

// file: dps_cvt_filter.sv
`timescale 1ns/100ps
`default_nettype none
// First-order correction stand-in for CVT transient removal
module dps_cvt_filter (
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    input  wire logic               enable,
    input  wire logic               sampleStb,
    input  wire dps_pkg::dps_cvt_s  tc,
    input  wire dps_pkg::dps_phasor_s vIn,
    output dps_pkg::dps_phasor_s    vOut
);
    dps_pkg::dps_phasor_s prev_ff;
    dps_pkg::dps_phasor_s vOut_ff;

    function automatic logic [15:0] corr(input logic [15:0] x, input logic [15:0] p, input logic [9:0] t);
        logic [25:0] d;
        d = 26'($signed(x) - $signed(p)) * 26'(t);
        return 16'(x + 16'(d >>> 10));
    endfunction

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev_ff <= '0;
        end else if (sampleStb) begin
            prev_ff <= vIn;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            vOut_ff <= '0;
        end else if (!enable) begin
            vOut_ff <= vIn;
        end else if (sampleStb) begin
            // Mean of first and third keeps the weight inside ten bits
            vOut_ff.re <= corr(vIn.re, prev_ff.re, 10'((11'(tc.first) + 11'(tc.third)) >> 1));
            vOut_ff.im <= corr(vIn.im, prev_ff.im, tc.second);
        end
    end

    assign vOut = vOut_ff;
endmodule
`default_nettype wire

// file: dps_polar_select.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - One of three sources feeds all zones
// - Polarizing output is memory or measured V1
// - Memory voltage also feeds directional supervision
// - Memory hold 5 to 25 cycles, default 10
// - After hold, above 10% uses measured
// - Memory valid after five cycles above 80%
// - Memory frozen at fault start while used
// - Force-self selects measured voltage always
// - Force-memory selects memory regardless of magnitude
// - Both forces low follow normal logic
// - Force-self wins over force-memory
// - Enable setting inserts CVT filter, reset off
// - Time constants 0.25 to 10 ms, default 1
// - One setting set serves all ten zones
module dps_polar_select (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic                  cycleStb,
    input  wire dps_pkg::dps_src_s     srcLine,
    input  wire dps_pkg::dps_src_s     srcBkr1,
    input  wire dps_pkg::dps_src_s     srcBkr2,
    input  wire logic [1:0]            srcSel,
    input  wire logic [15:0]           vNominal,
    input  wire logic [4:0]            memDuration,
    input  wire logic                  forceSelf,
    input  wire logic                  forceMemory,
    input  wire logic                  cvtEnable,
    input  wire dps_pkg::dps_cvt_s     cvtTc,
    output dps_pkg::dps_phasor_s       polarV,
    output dps_pkg::dps_phasor_s       dirMemV,
    output dps_pkg::dps_phasor_s       zoneI,
    output logic                       memInUse,
    output logic                       memValid
);
    // ****************************************
    // Settings capture
    // ****************************************
    logic [4:0]        memDur_ff;
    logic [1:0]        srcSel_ff;
    logic              cvtEn_ff;
    dps_pkg::dps_cvt_s cvtTc_ff;

    function automatic logic [4:0] clampDur(input logic [4:0] d);
        if (d < dps_pkg::MEM_DUR_MIN) return dps_pkg::MEM_DUR_MIN;
        if (d > dps_pkg::MEM_DUR_MAX) return dps_pkg::MEM_DUR_MAX;
        return d;
    endfunction

    function automatic logic [9:0] clampTc(input logic [9:0] t);
        if (t < dps_pkg::CVT_TC_MIN) return dps_pkg::CVT_TC_MIN;
        if (t > dps_pkg::CVT_TC_MAX) return dps_pkg::CVT_TC_MAX;
        return t;
    endfunction

    // Settings are one shared set for all zones, so a single copy
    // shared zone settings
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            memDur_ff       <= dps_pkg::MEM_DUR_RST;
            srcSel_ff       <= dps_pkg::SRC_LINE;
            cvtEn_ff        <= 1'b0;
            cvtTc_ff.first  <= dps_pkg::CVT_TC_RST;
            cvtTc_ff.second <= dps_pkg::CVT_TC_RST;
            cvtTc_ff.third  <= dps_pkg::CVT_TC_RST;
        end else begin
            memDur_ff       <= clampDur(memDuration);
            srcSel_ff       <= (srcSel > dps_pkg::SRC_BKR2) ? dps_pkg::SRC_LINE : srcSel;
            cvtEn_ff        <= cvtEnable;
            cvtTc_ff.first  <= clampTc(cvtTc.first);
            cvtTc_ff.second <= clampTc(cvtTc.second);
            cvtTc_ff.third  <= clampTc(cvtTc.third);
        end
    end

    // ****************************************
    // Source selection and filter
    // ****************************************
    dps_pkg::dps_src_s src;
    dps_pkg::dps_phasor_s vFilt;

    always_comb begin
        case (srcSel_ff)
            dps_pkg::SRC_BKR1: src = srcBkr1;
            dps_pkg::SRC_BKR2: src = srcBkr2;
            default:           src = srcLine;
        endcase
    end

    dps_cvt_filter u_cvt (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .enable    (cvtEn_ff),
        .sampleStb (cycleStb),
        .tc        (cvtTc_ff),
        .vIn       (src.v1),
        .vOut      (vFilt)
    );

    // ****************************************
    // Magnitude thresholds
    // ****************************************
    logic [22:0] magScaled;
    logic [22:0] nomValid;
    logic [22:0] nomRestore;
    logic        aboveValid;
    logic        aboveRestore;
    assign magScaled    = 23'(src.mag) * 23'd100;
    assign nomValid     = 23'(vNominal) * 23'(dps_pkg::PCT_VALID);
    assign nomRestore   = 23'(vNominal) * 23'(dps_pkg::PCT_RESTORE);
    assign aboveValid   = magScaled > nomValid;
    assign aboveRestore = magScaled > nomRestore;

    // ****************************************
    // Memory state machine
    // ****************************************
    dps_pkg::dps_mem_e state_ff;
    dps_pkg::dps_mem_e nxt_state;
    logic [2:0]        validCnt_ff;
    logic [4:0]        holdCnt_ff;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            validCnt_ff <= 3'h0;
        end else if (!aboveValid) begin
            validCnt_ff <= 3'h0;
        end else if (cycleStb && validCnt_ff < dps_pkg::VALID_CYCLES) begin
            validCnt_ff <= validCnt_ff + 3'h1;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            dps_pkg::ST_IDLE:  if (validCnt_ff == dps_pkg::VALID_CYCLES) nxt_state = dps_pkg::ST_VALID;
            dps_pkg::ST_VALID: if (!aboveValid) nxt_state = dps_pkg::ST_HOLD;
            dps_pkg::ST_HOLD:  if (holdCnt_ff >= memDur_ff) nxt_state = dps_pkg::ST_CHECK;
            dps_pkg::ST_CHECK: if (aboveRestore) nxt_state = dps_pkg::ST_IDLE;
            default:           nxt_state = dps_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= dps_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            holdCnt_ff <= 5'h00;
        end else if (state_ff != dps_pkg::ST_HOLD) begin
            holdCnt_ff <= 5'h00;
        end else if (cycleStb && holdCnt_ff < memDur_ff) begin
            holdCnt_ff <= holdCnt_ff + 5'h01;
        end
    end

    // ****************************************
    // Memory voltage
    // ****************************************
    dps_pkg::dps_phasor_s memV_ff;

    // track while healthy, freeze on fault
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            memV_ff <= '0;
        end else if (state_ff == dps_pkg::ST_VALID && aboveValid) begin
            memV_ff <= vFilt;
        end
    end

    // ****************************************
    // Polarization select
    // ****************************************
    logic useMem;
    always_comb begin
        if (forceSelf) begin
            useMem = 1'b0;
        end else if (forceMemory) begin
            useMem = 1'b1;
        end else begin
            useMem = (state_ff == dps_pkg::ST_HOLD) || (state_ff == dps_pkg::ST_CHECK);
        end
    end

    dps_pkg::dps_phasor_s polarV_ff;
    dps_pkg::dps_phasor_s dirMemV_ff;
    dps_pkg::dps_phasor_s zoneI_ff;
    logic                 memInUse_ff;
    logic                 memValid_ff;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            polarV_ff   <= '0;
            dirMemV_ff  <= '0;
            zoneI_ff    <= '0;
            memInUse_ff <= 1'b0;
            memValid_ff <= 1'b0;
        end else begin
            polarV_ff   <= useMem ? memV_ff : vFilt;
            dirMemV_ff  <= memV_ff;
            zoneI_ff    <= src.i1;
            memInUse_ff <= useMem;
            memValid_ff <= (state_ff != dps_pkg::ST_IDLE);
        end
    end

    assign polarV   = polarV_ff;
    assign dirMemV  = dirMemV_ff;
    assign zoneI    = zoneI_ff;
    assign memInUse = memInUse_ff;
    assign memValid = memValid_ff;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_selfForced;
        forceSelf;
    endsequence

    a_self_wins: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_selfForced |=> !memInUse) else $error("self polarization not forced");
    a_force_prio: assert property (@(posedge sys_clk) disable iff (!nrst)
        (forceSelf && forceMemory) |=> !memInUse) else $error("force priority wrong");
    a_mem_forced: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!forceSelf && forceMemory) |=> memInUse) else $error("memory not forced");
    a_hold_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
        holdCnt_ff <= dps_pkg::MEM_DUR_MAX) else $error("hold count overran");
    a_mem_frozen: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_ff == dps_pkg::ST_HOLD) |=> $stable(memV_ff)) else $error("memory not frozen");
    a_valid_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_ff == dps_pkg::ST_IDLE && nxt_state == dps_pkg::ST_VALID)
        |-> validCnt_ff == dps_pkg::VALID_CYCLES) else $error("memory valid too early");
    a_check_exit: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_ff == dps_pkg::ST_CHECK && !aboveRestore) |=> state_ff == dps_pkg::ST_CHECK)
        else $error("left memory at low voltage");
    a_polar_value: assert property (@(posedge sys_clk) disable iff (!nrst)
        !useMem |=> polarV == $past(vFilt)) else $error("polar value wrong");
    a_hold_expiry: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_ff == dps_pkg::ST_HOLD && holdCnt_ff < memDur_ff) |=> state_ff != dps_pkg::ST_CHECK)
        else $error("hold expired early");
endmodule
`default_nettype wire

// file: dps_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Source and cycle strobe model
// ****************************************
module dps_src_model #(
    parameter int STB_DIV = 8
) (
    input  wire logic          sys_clk,
    input  wire logic          nrst,
    input  wire logic [7:0]    levelPct,
    input  wire logic [15:0]   vBase,
    output logic               cycleStb,
    output dps_pkg::dps_src_s  srcLine,
    output dps_pkg::dps_src_s  srcBkr1,
    output dps_pkg::dps_src_s  srcBkr2
);
    logic [7:0]  divCnt_ff;
    logic [15:0] magNow;

    // One clock wide strobe per power-system cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            divCnt_ff <= 8'h00;
            cycleStb  <= 1'b0;
        end else begin
            cycleStb  <= (divCnt_ff == 8'(STB_DIV - 1));
            divCnt_ff <= (divCnt_ff == 8'(STB_DIV - 1)) ? 8'h00 : divCnt_ff + 8'h01;
        end
    end

    // Each source differs by its index so a wrong pick shows
    always_comb begin
        magNow          = 16'((32'h0000_4000 * levelPct) / 32'h0000_0064);
        srcLine.v1      = {vBase, ~vBase};
        srcBkr1.v1      = {vBase + 16'h0001, ~vBase};
        srcBkr2.v1      = {vBase + 16'h0002, ~vBase};
        srcLine.i1      = {16'h0100, 16'h0200};
        srcBkr1.i1      = {16'h0101, 16'h0201};
        srcBkr2.i1      = {16'h0102, 16'h0202};
        srcLine.mag     = magNow;
        srcBkr1.mag     = magNow;
        srcBkr2.mag     = magNow;
    end
endmodule
`default_nettype wire

// file: dps_polar_select_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dps_polar_select_tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cycleStb;
    dps_pkg::dps_src_s srcLine, srcBkr1, srcBkr2;
    logic [1:0] srcSel = 2'h0;
    logic [4:0] memDuration = 5'h0A;
    logic forceSelf = 1'b0;
    logic forceMemory = 1'b0;
    logic cvtEnable = 1'b0;
    dps_pkg::dps_cvt_s cvtTc = {10'h064, 10'h064, 10'h064};
    logic [7:0] levelPct = 8'h00;
    logic [15:0] vBase = 16'h1234;
    dps_pkg::dps_phasor_s polarV, dirMemV, zoneI;
    logic memInUse, memValid;
    int failures = 0;
    int comparisons = 0;

    always #5 sys_clk = ~sys_clk;

    dps_src_model #(.STB_DIV(8)) model (.sys_clk(sys_clk), .nrst(nrst), .levelPct(levelPct), .vBase(vBase),
        .cycleStb(cycleStb), .srcLine(srcLine), .srcBkr1(srcBkr1), .srcBkr2(srcBkr2));

    dps_polar_select dut (.sys_clk(sys_clk), .nrst(nrst), .cycleStb(cycleStb), .srcLine(srcLine),
        .srcBkr1(srcBkr1), .srcBkr2(srcBkr2), .srcSel(srcSel), .vNominal(16'h4000),
        .memDuration(memDuration), .forceSelf(forceSelf), .forceMemory(forceMemory),
        .cvtEnable(cvtEnable), .cvtTc(cvtTc), .polarV(polarV), .dirMemV(dirMemV), .zoneI(zoneI),
        .memInUse(memInUse), .memValid(memValid));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic clks(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Counts strobes seen by the design, then lets settled values land
    task automatic stbs(input int n);
        repeat (n) begin
            @(posedge sys_clk iff cycleStb === 1'b1);
        end
        clks(2);
    endtask

    task automatic t_establish();
        @(posedge sys_clk) levelPct <= 8'h5A;
        stbs(4);
        chk(32'(memValid), 32'h0000_0000, "memory valid too early");
        stbs(2);
        chk(32'(memValid), 32'h0000_0001, "memory not valid");
    endtask

    task automatic t_hold_recover();
        // Below minimum so the clamped hold of five cycles applies
        @(posedge sys_clk) memDuration <= 5'h03;
        @(posedge sys_clk) levelPct <= 8'h32;
        stbs(1);
        chk(32'(memInUse), 32'h0000_0001, "hold did not start");
        @(posedge sys_clk) vBase <= 16'h5678;
        stbs(3);
        chk(32'(memInUse), 32'h0000_0001, "hold ended before interval");
        chk(polarV, {16'h1234, ~16'h1234}, "memory not frozen");
        chk(dirMemV, {16'h1234, ~16'h1234}, "directional memory wrong");
        stbs(3);
        chk(32'(memInUse), 32'h0000_0000, "measured not restored");
        chk(polarV, {16'h5678, ~16'h5678}, "polarizing not measured");
    endtask

    task automatic t_hold_low();
        @(posedge sys_clk) levelPct <= 8'h5A;
        stbs(6);
        @(posedge sys_clk) levelPct <= 8'h05;
        stbs(8);
        chk(32'(memInUse), 32'h0000_0001, "memory dropped at low voltage");
        chk(polarV, {16'h5678, ~16'h5678}, "low voltage memory wrong");
    endtask

    task automatic t_force();
        @(posedge sys_clk) vBase <= 16'h0F0F;
        @(posedge sys_clk) forceSelf <= 1'b1;
        clks(3);
        chk(32'(memInUse), 32'h0000_0000, "force self ignored");
        chk(polarV, {16'h0F0F, ~16'h0F0F}, "force self value");
        // Both forces high on purpose, despite the advice against it
        @(posedge sys_clk) forceMemory <= 1'b1;
        clks(3);
        chk(32'(memInUse), 32'h0000_0000, "self did not win");
        @(posedge sys_clk) forceSelf <= 1'b0;
        @(posedge sys_clk) levelPct <= 8'h5A;
        clks(3);
        chk(32'(memInUse), 32'h0000_0001, "force memory ignored");
        @(posedge sys_clk) forceMemory <= 1'b0;
        stbs(8);
        chk(32'(memInUse), 32'h0000_0000, "normal logic not resumed");
    endtask

    task automatic t_source();
        logic [1:0] pick;
        for (int s = 1; s <= 4; s++) begin
            @(posedge sys_clk) srcSel <= 2'(s);
            clks(4);
            pick = (s == 3) ? 2'h0 : 2'(s & 3);
            chk(zoneI, {16'h0100 + 16'(pick), 16'h0200 + 16'(pick)}, "source current wrong");
            chk(polarV, {16'h0F0F + 16'(pick), ~16'h0F0F}, "source voltage wrong");
        end
    endtask

    task automatic t_filter();
        @(posedge sys_clk) cvtTc <= {10'h0C8, 10'h064, 10'h032};
        @(posedge sys_clk) cvtEnable <= 1'b1;
        stbs(2);
        chk(polarV, {16'h0F0F, ~16'h0F0F}, "filter altered steady input");
        @(posedge sys_clk) vBase <= 16'h1F0F;
        stbs(1);
        comparisons++;
        if (polarV.re === 16'h1F0F) begin
            failures++;
            $display("[ERR] %0t filter did not act on step", $time);
        end
        stbs(1);
        chk(polarV, {16'h1F0F, ~16'h1F0F}, "filter did not settle");
    endtask

    task automatic give_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        clks(1);
        chk(polarV, 32'h0000_0000, "polarizing not cleared");
        chk(32'(memValid), 32'h0000_0000, "valid not cleared");
        clks(1);
        chk(polarV, {16'h1234, ~16'h1234}, "filter not bypassed");
        t_establish();
        t_hold_recover();
        t_hold_low();
        t_force();
        t_source();
        t_filter();
        give_verdict();
    end

    initial begin
        #50000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule
`default_nettype wire
